// *** hdl/ttcu_pkg.sv ***
// Operation
// - Timers 0/1 sample count pin once per machine cycle at C4; high-then-low is an edge.
// - Counts update at C3; a detected edge counts in the following machine cycle.
// - Mode register bit 2 / bit 6 select clock or pin counting for timer 0 / 1.
// - Clock counting runs at 1/12 rate when speed bit is zero, 1/4 when one.
// - Mode 0 is 13 bits: high byte plus five low bits; upper low bits ignored.
// - Timers 0/1 count only with run bit set and gate clear or interrupt pin high, except timer 0 high byte and timer 1 while timer 0 is split.
// - Mode 0 rollover from 1FFFh to 0000h sets the overflow flag.
// - Mode 1 equals mode 0 but uses the full 16-bit value.
// - Mode 2 low byte counts; rollover sets flag and reloads from high byte.
// - Mode 3 splits timer 0: low uses timer 0 controls, high uses timer 1 run/flag.
// - Timer 1 in mode 3 freezes; with timer 0 split it free-counts clocks without flag.
// - Timer 2 counts pin edges or divided clock per function bit, gated by run bit.
// - Capture mode is a 16-bit up-counter; FFFFh rollover sets the overflow flag.
// - Capture mode with external enable: pin edge copies count and sets external flag.
// - With clear-on-capture set, the timer 2 count is zeroed after each capture.
// - Up auto-reload: rollover sets flag and reloads; enabled pin edge also reloads.
// - Up/down mode takes direction from external pin level; up overflow reloads.
// - Down count equal to capture loads FFFFh; reloads set flag, toggle external flag.
// - Receive or transmit clock select gives baud mode: reload without overflow flag.
// - Baud mode with external enable: pin falling edge sets external flag and requests.
package ttcu_pkg;

  localparam logic [7:0] ADDR_TIMER_MODE = 8'h00;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_T0_COUNT_LOW = 8'h0C;
  localparam logic [7:0] ADDR_T0_COUNT_HIGH = 8'h10;
  localparam logic [7:0] ADDR_T1_COUNT_LOW = 8'h14;
  localparam logic [7:0] ADDR_T1_COUNT_HIGH = 8'h18;
  localparam logic [7:0] ADDR_T2_CONTROL = 8'h1C;
  localparam logic [7:0] ADDR_T2_MODE = 8'h20;
  localparam logic [7:0] ADDR_T2_CAPTURE_LOW = 8'h24;
  localparam logic [7:0] ADDR_T2_CAPTURE_HIGH = 8'h28;
  localparam logic [7:0] ADDR_T2_COUNT_LOW = 8'h2C;
  localparam logic [7:0] ADDR_T2_COUNT_HIGH = 8'h30;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] T2_ALL_ONES = 16'hFFFF;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;

  // Machine cycle is four clocks, phases C1..C4
  localparam logic [1:0] PHASE_C3 = 2'h2;
  localparam logic [1:0] PHASE_C4 = 2'h3;
  // Divide-by-12 is one tick every third machine cycle
  localparam logic [1:0] PRESCALE_LAST = 2'h2;

  typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT8} ttcu_mode_e;

  typedef struct packed {
    logic t1Gate;
    logic t1Function;
    ttcu_mode_e t1Mode;
    logic t0Gate;
    logic t0Function;
    ttcu_mode_e t0Mode;
  } ttcu_tmode_s;

  typedef struct packed {
    logic t1OverflowFlag;
    logic t1RunBit;
    logic t0OverflowFlag;
    logic t0RunBit;
    logic [3:0] reserved;
  } ttcu_tctl_s;

  typedef struct packed {
    logic [1:0] reservedHigh;
    logic t2SpeedBit;
    logic t1SpeedBit;
    logic t0SpeedBit;
    logic [2:0] reservedLow;
  } ttcu_clkctl_s;

  typedef struct packed {
    logic t2OverflowFlag;
    logic t2ExternalFlag;
    logic receiveClockSelect;
    logic transmitClockSelect;
    logic t2ExternalEnable;
    logic t2RunBit;
    logic t2FunctionBit;
    logic captureReloadSelect;
  } ttcu_t2ctl_s;

  typedef struct packed {
    logic [5:0] reserved;
    logic clearOnCaptureBit;
    logic upDownEnable;
  } ttcu_t2mode_s;

endpackage : ttcu_pkg

// *** hdl/ttcu_pin_sampler.sv ***
`timescale 1ns/10ps
module ttcu_pin_sampler
  import ttcu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] phase,
  input wire logic pinIn,
  output logic level,
  output logic fallEdge
);

  logic sync1_q, sync2_q;
  logic sample_q, sample_d;
  logic pending_q, pending_d;

  always_comb
  begin
    sample_d = sample_q;
    pending_d = pending_q;
    if (phase == PHASE_C4)
    begin
      sample_d = sync2_q;
      if (sample_q && !sync2_q)
        pending_d = 1'b1;
    end
    if (phase == PHASE_C3)
      pending_d = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sample_q <= 1'b0;
      pending_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      sample_q <= sample_d;
      pending_q <= pending_d;
    end
  end

  assign level = sample_q;
  // Edge seen at C4 acts at C3 of the next machine cycle
  assign fallEdge = pending_q && (phase == PHASE_C3);

endmodule : ttcu_pin_sampler

// *** hdl/ttcu_top.sv ***
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
module ttcu_top
  import ttcu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic countPinA,
  input wire logic countPinB,
  input wire logic countPinC,
  input wire logic t2ExternalPin,
  input wire logic extIntPin0,
  input wire logic extIntPin1,
  output logic t0OverflowFlag,
  output logic t1OverflowFlag,
  output logic t2IrqRequest
);

  function automatic logic [8:0] inc8(input logic [7:0] v);
    inc8 = {1'b0, v} + 9'h001;
  endfunction : inc8

  // Returns {overflow, high, low} for one count step in modes 0 to 2
  function automatic logic [16:0] stepT01(input ttcu_mode_e m, input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8 = inc8(lo);
    stepT01 = {1'b0, hi, lo};
    unique case (m)
      MODE_13BIT: stepT01 = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      MODE_16BIT: stepT01 = s16;
      MODE_RELOAD8: stepT01 = s8[8] ? {1'b1, hi, hi} : {1'b0, hi, s8[7:0]};
      MODE_SPLIT8: stepT01 = {1'b0, hi, lo};
    endcase
  endfunction : stepT01

  function automatic logic regHit(input logic [7:0] adr, input logic [7:0] offset);
    regHit = (adr == offset);
  endfunction : regHit

  ttcu_tmode_s tmode_q, tmode_d;
  ttcu_tctl_s tctl_q, tctl_d;
  ttcu_clkctl_s clkctl_q, clkctl_d;
  ttcu_t2ctl_s t2ctl_q, t2ctl_d;
  ttcu_t2mode_s t2mode_q, t2mode_d;
  logic [7:0] t0Lo_q, t0Lo_d, t0Hi_q, t0Hi_d, t1Lo_q, t1Lo_d, t1Hi_q, t1Hi_d;
  logic [15:0] t2Cap_q, t2Cap_d, t2Cnt_q, t2Cnt_d;
  logic [1:0] phase_q, phase_d, pre_q, pre_d;
  logic ack_q, ack_d, t2Irq_q, t2Irq_d;
  logic [31:0] rdat_q, rdat_d;

  logic edgeA, edgeB, edgeC, edgeEx, levelEx, levelInt0, levelInt1;

  ttcu_pin_sampler u_pin_a (.sys_clk(sys_clk), .reset_n(reset_n), .phase(phase_q),
    .pinIn(countPinA), .level(), .fallEdge(edgeA));
  ttcu_pin_sampler u_pin_b (.sys_clk(sys_clk), .reset_n(reset_n), .phase(phase_q),
    .pinIn(countPinB), .level(), .fallEdge(edgeB));
  ttcu_pin_sampler u_pin_c (.sys_clk(sys_clk), .reset_n(reset_n), .phase(phase_q),
    .pinIn(countPinC), .level(), .fallEdge(edgeC));
  ttcu_pin_sampler u_pin_ex (.sys_clk(sys_clk), .reset_n(reset_n), .phase(phase_q),
    .pinIn(t2ExternalPin), .level(levelEx), .fallEdge(edgeEx));
  ttcu_pin_sampler u_int0 (.sys_clk(sys_clk), .reset_n(reset_n), .phase(phase_q),
    .pinIn(extIntPin0), .level(levelInt0), .fallEdge());
  ttcu_pin_sampler u_int1 (.sys_clk(sys_clk), .reset_n(reset_n), .phase(phase_q),
    .pinIn(extIntPin1), .level(levelInt1), .fallEdge());

  // Bus write lands on the edge where the master sees ack
  logic busReq, busWrite;
  logic [7:0] wbyte;
  assign busReq = wb_cyc_i && wb_stb_i;
  assign busWrite = busReq && ack_q && wb_we_i && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  // Time base
  logic atC3, div12Tick, clkTick0, clkTick1, clkTick2;
  always_comb
  begin
    phase_d = phase_q + 2'h1;
    pre_d = pre_q;
    if (phase_q == PHASE_C4)
      pre_d = (pre_q == PRESCALE_LAST) ? 2'h0 : pre_q + 2'h1;
  end
  assign atC3 = (phase_q == PHASE_C3);
  assign div12Tick = atC3 && (pre_q == PRESCALE_LAST);
  assign clkTick0 = clkctl_q.t0SpeedBit ? atC3 : div12Tick;
  assign clkTick1 = clkctl_q.t1SpeedBit ? atC3 : div12Tick;
  assign clkTick2 = clkctl_q.t2SpeedBit ? atC3 : div12Tick;

  // Count enables
  logic t0Split, t0Tick, t0HiTick, t1Tick, t2Tick;
  assign t0Split = (tmode_q.t0Mode == MODE_SPLIT8);
  assign t0Tick = tctl_q.t0RunBit && (!tmode_q.t0Gate || levelInt0)
                  && (tmode_q.t0Function ? edgeA : clkTick0);
  assign t0HiTick = t0Split && tctl_q.t1RunBit && clkTick0;
  always_comb
  begin
    if (tmode_q.t1Mode == MODE_SPLIT8)
      t1Tick = 1'b0;
    else if (t0Split)
      t1Tick = clkTick1;
    else
      t1Tick = tctl_q.t1RunBit && (!tmode_q.t1Gate || levelInt1)
               && (tmode_q.t1Function ? edgeB : clkTick1);
  end
  assign t2Tick = t2ctl_q.t2RunBit && (t2ctl_q.t2FunctionBit ? edgeC : clkTick2);

  logic t2Baud, t2UpDown, t2ExtEvent;
  assign t2Baud = t2ctl_q.receiveClockSelect || t2ctl_q.transmitClockSelect;
  assign t2UpDown = !t2Baud && !t2ctl_q.captureReloadSelect && t2mode_q.upDownEnable;
  assign t2ExtEvent = t2ctl_q.t2ExternalEnable && edgeEx;

  always_comb
  begin
    logic [16:0] st;
    logic [8:0] s8;
    logic [16:0] s16;
    logic t0Set, t1Set, tf2Set, exf2Set, exf2Toggle;
    st = 17'h00000;
    s8 = 9'h000;
    s16 = 17'h00000;
    t0Set = 1'b0;
    t1Set = 1'b0;
    tf2Set = 1'b0;
    exf2Set = 1'b0;
    exf2Toggle = 1'b0;
    tmode_d = tmode_q;
    tctl_d = tctl_q;
    clkctl_d = clkctl_q;
    t2ctl_d = t2ctl_q;
    t2mode_d = t2mode_q;
    t0Lo_d = t0Lo_q;
    t0Hi_d = t0Hi_q;
    t1Lo_d = t1Lo_q;
    t1Hi_d = t1Hi_q;
    t2Cap_d = t2Cap_q;
    t2Cnt_d = t2Cnt_q;

    // Timer 0
    if (t0Split)
    begin
      if (t0Tick)
      begin
        s8 = inc8(t0Lo_q);
        t0Lo_d = s8[7:0];
        t0Set = s8[8];
      end
      if (t0HiTick)
      begin
        s8 = inc8(t0Hi_q);
        t0Hi_d = s8[7:0];
        t1Set = s8[8];
      end
    end
    else if (t0Tick)
    begin
      st = stepT01(tmode_q.t0Mode, t0Lo_q, t0Hi_q);
      {t0Set, t0Hi_d, t0Lo_d} = st;
    end

    // Timer 1; flag is owned by timer 0 high byte while split
    if (t1Tick)
    begin
      st = stepT01(tmode_q.t1Mode, t1Lo_q, t1Hi_q);
      {t1Hi_d, t1Lo_d} = st[15:0];
      if (!t0Split)
        t1Set = st[16];
    end

    // Timer 2
    s16 = {1'b0, t2Cnt_q} + 17'h00001;
    if (t2Baud)
    begin
      if (t2Tick)
        t2Cnt_d = s16[16] ? t2Cap_q : s16[15:0];
      exf2Set = t2ExtEvent;
    end
    else if (t2ctl_q.captureReloadSelect)
    begin
      if (t2Tick)
      begin
        t2Cnt_d = s16[15:0];
        tf2Set = s16[16];
      end
      if (t2ExtEvent)
      begin
        t2Cap_d = t2Cnt_q;
        exf2Set = 1'b1;
        if (t2mode_q.clearOnCaptureBit)
          t2Cnt_d = RESET_WORD;
      end
    end
    else if (!t2mode_q.upDownEnable)
    begin
      if (t2Tick)
      begin
        t2Cnt_d = s16[16] ? t2Cap_q : s16[15:0];
        tf2Set = s16[16];
      end
      if (t2ExtEvent)
      begin
        t2Cnt_d = t2Cap_q;
        exf2Set = 1'b1;
      end
    end
    else if (t2Tick)
    begin
      if (levelEx)
      begin
        t2Cnt_d = s16[16] ? t2Cap_q : s16[15:0];
        tf2Set = s16[16];
        exf2Toggle = s16[16];
      end
      else if (t2Cnt_q == t2Cap_q)
      begin
        t2Cnt_d = T2_ALL_ONES;
        tf2Set = 1'b1;
        exf2Toggle = 1'b1;
      end
      else
        t2Cnt_d = t2Cnt_q - 16'h0001;
    end

    // Software writes; counts written by software override a same-cycle step
    if (busWrite)
    begin
      if (regHit(wb_adr_i, ADDR_TIMER_MODE))
        tmode_d = ttcu_tmode_s'(wbyte);
      if (regHit(wb_adr_i, ADDR_TIMER_CONTROL))
        tctl_d = ttcu_tctl_s'({wbyte[7:4], 4'h0});
      if (regHit(wb_adr_i, ADDR_CLOCK_CONTROL))
        clkctl_d = ttcu_clkctl_s'({2'h0, wbyte[5:3], 3'h0});
      if (regHit(wb_adr_i, ADDR_T2_CONTROL))
        t2ctl_d = ttcu_t2ctl_s'(wbyte);
      if (regHit(wb_adr_i, ADDR_T2_MODE))
        t2mode_d = ttcu_t2mode_s'({6'h00, wbyte[1:0]});
      if (regHit(wb_adr_i, ADDR_T0_COUNT_LOW))
        t0Lo_d = wbyte;
      if (regHit(wb_adr_i, ADDR_T0_COUNT_HIGH))
        t0Hi_d = wbyte;
      if (regHit(wb_adr_i, ADDR_T1_COUNT_LOW))
        t1Lo_d = wbyte;
      if (regHit(wb_adr_i, ADDR_T1_COUNT_HIGH))
        t1Hi_d = wbyte;
      if (regHit(wb_adr_i, ADDR_T2_CAPTURE_LOW))
        t2Cap_d[7:0] = wbyte;
      if (regHit(wb_adr_i, ADDR_T2_CAPTURE_HIGH))
        t2Cap_d[15:8] = wbyte;
      if (regHit(wb_adr_i, ADDR_T2_COUNT_LOW))
        t2Cnt_d[7:0] = wbyte;
      if (regHit(wb_adr_i, ADDR_T2_COUNT_HIGH))
        t2Cnt_d[15:8] = wbyte;
    end

    // Hardware sets win over a software clear in the same cycle
    tctl_d.t0OverflowFlag = tctl_d.t0OverflowFlag | t0Set;
    tctl_d.t1OverflowFlag = tctl_d.t1OverflowFlag | t1Set;
    t2ctl_d.t2OverflowFlag = t2ctl_d.t2OverflowFlag | tf2Set;
    t2ctl_d.t2ExternalFlag = (t2ctl_d.t2ExternalFlag ^ exf2Toggle) | exf2Set;

    // External flag cannot request while up/down counting
    t2Irq_d = t2ctl_d.t2OverflowFlag || (t2ctl_d.t2ExternalFlag && !t2UpDown);
  end

  always_comb
  begin
    ack_d = busReq && !ack_q;
    rdat_d = rdat_q;
    if (busReq && !ack_q)
    begin
      rdat_d = 32'h00000000;
      unique case (1'b1)
        regHit(wb_adr_i, ADDR_TIMER_MODE): rdat_d[7:0] = tmode_q;
        regHit(wb_adr_i, ADDR_TIMER_CONTROL): rdat_d[7:0] = tctl_q;
        regHit(wb_adr_i, ADDR_CLOCK_CONTROL): rdat_d[7:0] = clkctl_q;
        regHit(wb_adr_i, ADDR_T0_COUNT_LOW): rdat_d[7:0] = t0Lo_q;
        regHit(wb_adr_i, ADDR_T0_COUNT_HIGH): rdat_d[7:0] = t0Hi_q;
        regHit(wb_adr_i, ADDR_T1_COUNT_LOW): rdat_d[7:0] = t1Lo_q;
        regHit(wb_adr_i, ADDR_T1_COUNT_HIGH): rdat_d[7:0] = t1Hi_q;
        regHit(wb_adr_i, ADDR_T2_CONTROL): rdat_d[7:0] = t2ctl_q;
        regHit(wb_adr_i, ADDR_T2_MODE): rdat_d[7:0] = t2mode_q;
        regHit(wb_adr_i, ADDR_T2_CAPTURE_LOW): rdat_d[7:0] = t2Cap_q[7:0];
        regHit(wb_adr_i, ADDR_T2_CAPTURE_HIGH): rdat_d[7:0] = t2Cap_q[15:8];
        regHit(wb_adr_i, ADDR_T2_COUNT_LOW): rdat_d[7:0] = t2Cnt_q[7:0];
        regHit(wb_adr_i, ADDR_T2_COUNT_HIGH): rdat_d[7:0] = t2Cnt_q[15:8];
        default: rdat_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      tmode_q <= ttcu_tmode_s'(RESET_BYTE);
      tctl_q <= ttcu_tctl_s'(RESET_BYTE);
      clkctl_q <= ttcu_clkctl_s'(RESET_BYTE);
      t2ctl_q <= ttcu_t2ctl_s'(RESET_BYTE);
      t2mode_q <= ttcu_t2mode_s'(RESET_BYTE);
      t0Lo_q <= RESET_BYTE;
      t0Hi_q <= RESET_BYTE;
      t1Lo_q <= RESET_BYTE;
      t1Hi_q <= RESET_BYTE;
      t2Cap_q <= RESET_WORD;
      t2Cnt_q <= RESET_WORD;
      phase_q <= 2'h0;
      pre_q <= 2'h0;
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      t2Irq_q <= 1'b0;
    end
    else
    begin
      tmode_q <= tmode_d;
      tctl_q <= tctl_d;
      clkctl_q <= clkctl_d;
      t2ctl_q <= t2ctl_d;
      t2mode_q <= t2mode_d;
      t0Lo_q <= t0Lo_d;
      t0Hi_q <= t0Hi_d;
      t1Lo_q <= t1Lo_d;
      t1Hi_q <= t1Hi_d;
      t2Cap_q <= t2Cap_d;
      t2Cnt_q <= t2Cnt_d;
      phase_q <= phase_d;
      pre_q <= pre_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      t2Irq_q <= t2Irq_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign t0OverflowFlag = tctl_q.t0OverflowFlag;
  assign t1OverflowFlag = tctl_q.t1OverflowFlag;
  assign t2IrqRequest = t2Irq_q;

endmodule : ttcu_top

// *** sim/ttcu_top_asserts.sv ***
`timescale 1ns/10ps
module ttcu_top_asserts
  import ttcu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic countPinA,
  input wire logic countPinB,
  input wire logic countPinC,
  input wire logic t2ExternalPin,
  input wire logic extIntPin0,
  input wire logic extIntPin1,
  input wire logic t0OverflowFlag,
  input wire logic t1OverflowFlag,
  input wire logic t2IrqRequest
);
  // Mirror of the machine-cycle phase; both start at C1 when reset lets go
  logic [1:0] phaseQ;
  logic [1:0] phaseD;
  always_comb phaseD = phaseQ + 2'h1;
  always_ff @(posedge sys_clk) phaseQ <= reset_n ? phaseD : 2'h0;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked in one cycle");
  ack_needs_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  unmapped_read_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h30
    |-> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
  ctl_reserved_a: assert property (wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) == ADDR_TIMER_CONTROL |-> wb_dat_o[3:0] == 4'h0)
    else $error("reserved control bits not zero");
  t0_flag_c3_a: assert property ($rose(t0OverflowFlag) |-> phaseQ == PHASE_C4)
    else $error("timer 0 flag set off phase");
  t1_flag_c3_a: assert property ($rose(t1OverflowFlag) |-> phaseQ == PHASE_C4)
    else $error("timer 1 flag set off phase");
  t0_flag_sticky_a: assert property ($fell(t0OverflowFlag) |-> $past(wb_ack_o && wb_we_i))
    else $error("timer 0 flag cleared without write");
  t1_flag_sticky_a: assert property ($fell(t1OverflowFlag) |-> $past(wb_ack_o && wb_we_i))
    else $error("timer 1 flag cleared without write");

  cover property ($rose(t0OverflowFlag));
  cover property ($rose(t1OverflowFlag));
  cover property ($rose(t2IrqRequest));
endmodule : ttcu_top_asserts

bind ttcu_top ttcu_top_asserts ttcu_top_asserts_inst (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .countPinA, .countPinB,
  .countPinC, .t2ExternalPin, .extIntPin0, .extIntPin1, .t0OverflowFlag, .t1OverflowFlag,
  .t2IrqRequest);

// *** sim/ttcu_pin_model.sv ***
`timescale 1ns/10ps
module ttcu_pin_model (
  input wire logic sys_clk,
  output logic countPinA,
  output logic countPinB,
  output logic countPinC,
  output logic t2ExternalPin,
  output logic extIntPin0,
  output logic extIntPin1
);
  // Pins idle high, as with pull-ups
  logic [5:0] pinQ = 6'h3F;
  assign {extIntPin1, extIntPin0, t2ExternalPin, countPinC, countPinB, countPinA} = pinQ;

  task automatic setPin(input int idx, input logic v);
    @(posedge sys_clk);
    pinQ[idx] <= v;
  endtask : setPin

  // Each level lasts eight clocks so no edge is faster than clk/8
  task automatic pulse(input int idx);
    setPin(idx, 1'b0);
    repeat (7) @(posedge sys_clk);
    setPin(idx, 1'b1);
    repeat (7) @(posedge sys_clk);
  endtask : pulse
endmodule : ttcu_pin_model

// *** sim/ttcu_test.sv ***
`timescale 1ns/10ps
module ttcu_test
  import ttcu_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic countPinA, countPinB, countPinC, t2ExternalPin, extIntPin0, extIntPin1;
  logic t0OverflowFlag, t1OverflowFlag, t2IrqRequest;
  logic [2:0] flagVec;
  assign flagVec = {t2IrqRequest, t1OverflowFlag, t0OverflowFlag};
  int mismatches = 0;
  int nCompared = 0;
  int n;
  logic [7:0] rd;

  ttcu_top ttcu_top_inst (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .countPinA, .countPinB, .countPinC,
    .t2ExternalPin, .extIntPin0, .extIntPin1, .t0OverflowFlag, .t1OverflowFlag, .t2IrqRequest);
  ttcu_pin_model ttcu_pin_model_inst (.sys_clk, .countPinA, .countPinB, .countPinC,
    .t2ExternalPin, .extIntPin0, .extIntPin1);

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic wbCycle(input logic we, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (k >= 20) check(8'h00, 8'h01, "bus timeout");
  endtask : wbCycle

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    nCompared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic readCheck(input logic [7:0] a, input logic [7:0] exp);
    wbCycle(1'b0, a, 8'h00);
    check(rd, exp, "read");
  endtask : readCheck

  task automatic waitFlag(input int sel, input int lim);
    n = 0;
    while (flagVec[sel] !== 1'b1 && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask : waitFlag

  // Load one timer 0/1 count while stopped, then start with the given control byte
  task automatic setup(input logic [7:0] tm, input logic [7:0] ck, input logic [7:0] hiAdr,
                       input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ctl);
    wbCycle(1'b1, ADDR_TIMER_CONTROL, 8'h00);
    wbCycle(1'b1, ADDR_TIMER_MODE, tm);
    wbCycle(1'b1, ADDR_CLOCK_CONTROL, ck);
    wbCycle(1'b1, hiAdr, hi);
    wbCycle(1'b1, hiAdr - 8'h04, lo);
    wbCycle(1'b1, ADDR_TIMER_CONTROL, ctl);
  endtask : setup

  task automatic setupT2(input logic [7:0] md, input logic [7:0] cap, input logic [7:0] hi,
                         input logic [7:0] lo, input logic [7:0] ctl);
    wbCycle(1'b1, ADDR_T2_CONTROL, 8'h00);
    wbCycle(1'b1, ADDR_T2_MODE, md);
    wbCycle(1'b1, ADDR_T2_CAPTURE_LOW, cap);
    wbCycle(1'b1, ADDR_T2_CAPTURE_HIGH, cap);
    wbCycle(1'b1, ADDR_T2_COUNT_HIGH, hi);
    wbCycle(1'b1, ADDR_T2_COUNT_LOW, lo);
    wbCycle(1'b1, ADDR_CLOCK_CONTROL, 8'h20);
    wbCycle(1'b1, ADDR_T2_CONTROL, ctl);
  endtask : setupT2

  task automatic endOfTest();
    $display("compared %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : endOfTest

  initial
  begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    endOfTest();
  end

  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int a = 0; a <= 8'h30; a += 4) readCheck(a[7:0], RESET_BYTE);
    wbCycle(1'b1, 8'h34, 8'hFF);
    readCheck(8'h34, 8'h00);
    $display("test registers done");
    // Slow and fast time base; fast must overflow within ten clocks
    setup(8'h01, 8'h08, ADDR_T0_COUNT_HIGH, 8'hFF, 8'hFE, 8'h10);
    waitFlag(0, 30);
    check(8'(n <= 10), 8'h01, "fast rate");
    setup(8'h01, 8'h00, ADDR_T0_COUNT_HIGH, 8'hFF, 8'hFE, 8'h10);
    waitFlag(0, 40);
    check(8'(n > 10 && n <= 26), 8'h01, "slow rate");
    // Upper three low bits ignored: 13-bit value 1FFE
    setup(8'h00, 8'h08, ADDR_T0_COUNT_HIGH, 8'hFF, 8'hFE, 8'h10);
    waitFlag(0, 30);
    check({7'h0, t0OverflowFlag}, 8'h01, "mode 0 overflow");
    setup(8'h02, 8'h08, ADDR_T0_COUNT_HIGH, 8'hF0, 8'hFE, 8'h10);
    waitFlag(0, 30);
    wbCycle(1'b1, ADDR_TIMER_CONTROL, 8'h00);
    readCheck(ADDR_T0_COUNT_HIGH, 8'hF0);
    wbCycle(1'b0, ADDR_T0_COUNT_LOW, 8'h00);
    check({4'h0, rd[7:4]}, 8'h0F, "reload");
    $display("test timer modes done");
    ttcu_pin_model_inst.setPin(4, 1'b0);
    setup(8'h09, 8'h08, ADDR_T0_COUNT_HIGH, 8'hFF, 8'hFE, 8'h10);
    waitFlag(0, 40);
    check({7'h0, t0OverflowFlag}, 8'h00, "gated");
    ttcu_pin_model_inst.setPin(4, 1'b1);
    waitFlag(0, 30);
    check({7'h0, t0OverflowFlag}, 8'h01, "gate open");
    setup(8'h05, 8'h08, ADDR_T0_COUNT_HIGH, 8'hFF, 8'hFF, 8'h10);
    waitFlag(0, 40);
    check({7'h0, t0OverflowFlag}, 8'h00, "no edge");
    ttcu_pin_model_inst.pulse(0);
    waitFlag(0, 16);
    check({7'h0, t0OverflowFlag}, 8'h01, "pin edge");
    $display("test gate and pin done");
    setup(8'h30, 8'h10, ADDR_T1_COUNT_HIGH, 8'hFF, 8'hFF, 8'h40);
    waitFlag(1, 60);
    check({7'h0, t1OverflowFlag}, 8'h00, "timer 1 frozen");
    setup(8'h03, 8'h08, ADDR_T0_COUNT_HIGH, 8'hFF, 8'h00, 8'h40);
    waitFlag(1, 30);
    check({6'h0, t1OverflowFlag, t0OverflowFlag}, 8'h02, "split high");
    // Timer 1 on its own pin in reload mode, first with its gate pin low
    setup(8'hE0, 8'h00, ADDR_T1_COUNT_HIGH, 8'hFF, 8'hFF, 8'h40);
    ttcu_pin_model_inst.setPin(5, 1'b0);
    ttcu_pin_model_inst.pulse(1);
    check({7'h0, t1OverflowFlag}, 8'h00, "timer 1 gated");
    ttcu_pin_model_inst.setPin(5, 1'b1);
    ttcu_pin_model_inst.pulse(1);
    waitFlag(1, 16);
    check({7'h0, t1OverflowFlag}, 8'h01, "timer 1 pin");
    $display("test split done");
    setupT2(8'h00, 8'h00, 8'hFF, 8'hFE, 8'h05);
    waitFlag(2, 30);
    check({7'h0, t2IrqRequest}, 8'h01, "capture overflow");
    // Counter function: no clock counting, one pin edge rolls FFFF over
    setupT2(8'h00, 8'h00, 8'hFF, 8'hFF, 8'h07);
    waitFlag(2, 20);
    check({7'h0, t2IrqRequest}, 8'h00, "timer 2 no pin edge");
    ttcu_pin_model_inst.pulse(2);
    check({7'h0, t2IrqRequest}, 8'h01, "timer 2 pin count");
    setupT2(8'h00, 8'h00, 8'h12, 8'h34, 8'h0D);
    ttcu_pin_model_inst.pulse(3);
    readCheck(ADDR_T2_CAPTURE_HIGH, 8'h12);
    check({7'h0, t2IrqRequest}, 8'h01, "capture flag");
    setupT2(8'h02, 8'h00, 8'h12, 8'h34, 8'h0D);
    ttcu_pin_model_inst.pulse(3);
    readCheck(ADDR_T2_COUNT_HIGH, 8'h00);
    setupT2(8'h00, 8'h55, 8'hFF, 8'hFE, 8'h04);
    waitFlag(2, 30);
    readCheck(ADDR_T2_COUNT_HIGH, 8'h55);
    setupT2(8'h00, 8'h55, 8'h12, 8'h34, 8'h0C);
    ttcu_pin_model_inst.pulse(3);
    readCheck(ADDR_T2_COUNT_HIGH, 8'h55);
    check({7'h0, t2IrqRequest}, 8'h01, "reload flag");
    setupT2(8'h00, 8'h55, 8'hFF, 8'hFE, 8'h14);
    waitFlag(2, 30);
    check({7'h0, t2IrqRequest}, 8'h00, "baud no flag");
    readCheck(ADDR_T2_COUNT_HIGH, 8'h55);
    setupT2(8'h00, 8'h55, 8'h12, 8'h34, 8'h1C);
    ttcu_pin_model_inst.pulse(3);
    check({7'h0, t2IrqRequest}, 8'h01, "baud pin");
    ttcu_pin_model_inst.setPin(3, 1'b0);
    setupT2(8'h01, 8'h55, 8'h55, 8'h57, 8'h04);
    waitFlag(2, 30);
    check({7'h0, t2IrqRequest}, 8'h01, "down reload flag");
    readCheck(ADDR_T2_COUNT_HIGH, 8'hFF);
    readCheck(ADDR_T2_CONTROL, 8'hC4);
    wbCycle(1'b1, ADDR_T2_CONTROL, 8'h44);
    readCheck(ADDR_T2_CONTROL, 8'h44);
    check({7'h0, t2IrqRequest}, 8'h00, "updown external no request");
    ttcu_pin_model_inst.setPin(3, 1'b1);
    $display("test timer 2 done");
    endOfTest();
  end
endmodule : ttcu_test
